// >>> ulsce_regs.svh
// Register offsets, field positions, reset values and counts
`ifndef ULSCE_REGS_SVH
`define ULSCE_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ULSCE_STATUS_OFS 12'h000
`define ULSCE_CONTROL_OFS 12'h004

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define ULSCE_ST_LBK 7
`define ULSCE_ST_EDGE 6
`define ULSCE_ST_RX_INV 4
`define ULSCE_ST_WID 3
`define ULSCE_ST_LONG_BRK 2
`define ULSCE_ST_LIN_DET 1
`define ULSCE_ST_BUSY 0

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ULSCE_CT_RX_NINTH 7
`define ULSCE_CT_TX_NINTH 6
`define ULSCE_CT_DIR 5
`define ULSCE_CT_TX_INV 4
`define ULSCE_CT_OVR_EN 3
`define ULSCE_CT_NOISE_EN 2
`define ULSCE_CT_FRAME_EN 1
`define ULSCE_CT_PARITY_EN 0

// ----------------------------------------------------------------
// Reset values, bit-time counts and bus response codes
// ----------------------------------------------------------------
`define ULSCE_STATUS_RST 8'h00
`define ULSCE_CONTROL_RST 8'h00
`define ULSCE_TXBRK_SHORT 4'hA
`define ULSCE_TXBRK_LONG 4'hD
`define ULSCE_RXBRK_BASE 4'hA
`define ULSCE_RESP_OKAY 2'h0
`define ULSCE_RESP_SLVERR 2'h2

`endif

// >>> ulsce_pkg.sv
// Types shared by the line status and control block
package ulsce_pkg;

    // Transmit break sequencer states
    typedef enum logic [1:0]
    {
        ULSCE_TB_IDLE = 2'h1,
        ULSCE_TB_SEND = 2'h2
    } ulsce_tb_state_t;

    // Register byte
    typedef logic [7:0] ulsce_byte_t;

endpackage : ulsce_pkg

// >>> ulsce_top.sv
// Extended line status and control logic of an asynchronous serial port
`timescale 1ns/1ps
`include "ulsce_regs.svh"

module ulsce_top #(
    parameter int CNT_W = 4
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic [11:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [11:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic DATA_NINE_BITS,
    input wire logic RECEIVER_STANDBY,
    input wire logic LOOPBACK_SELECT,
    input wire logic RECEIVER_SOURCE_SELECT,
    input wire logic RX_BIT_TICK,
    input wire logic TX_BIT_TICK,
    input wire logic RX_PIN,
    input wire logic TX_PIN_I,
    output logic TX_PIN_O,
    output logic TX_PIN_OE,
    output logic RX_LINE,
    input wire logic TX_SERIAL_RAW,
    input wire logic TX_BREAK_REQ,
    output logic TX_BREAK_ACTIVE,
    output logic TX_BREAK_DONE,
    input wire logic CORE_START_VALID,
    input wire logic CORE_LINE_IDLE,
    input wire logic CORE_IDLE_SET,
    input wire logic CORE_FRAME_ERR_SET,
    input wire logic CORE_RXFULL_SET,
    output logic IDLE_SET_OUT,
    output logic FRAME_ERR_SET_OUT,
    output logic RXFULL_SET_OUT,
    input wire logic RX_NINTH_IN,
    input wire logic DATA_WRITE,
    output logic TX_NINTH_OUT,
    input wire logic OVERRUN_FLAG,
    input wire logic NOISE_FLAG,
    input wire logic FRAME_ERROR_FLAG,
    input wire logic PARITY_FLAG,
    output logic ERR_IRQ,
    output logic RECEIVE_BUSY_FLAG,
    output logic BREAK_DETECT
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (CNT_W < 4)
    begin : g_bad_cnt_w
        $error("CNT_W must be at least 4");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
    logic [11:0] awaddr_reg, awaddr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic wstrb_reg, wstrb_next;
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic bvalid_reg, bvalid_next, arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic do_wr, wr_stat, wr_ctrl;
    ulsce_pkg::ulsce_byte_t stat_rd, ctrl_reg, ctrl_next;
    logic [4:1] stat_cfg_reg, stat_cfg_next;
    logic lbk_flag_reg, lbk_flag_next, edge_flag_reg, edge_flag_next;
    logic busy_reg, busy_next, rx9_reg, rx9_next, tx9_out_reg, tx9_out_next;
    logic line_reg, line_next, line_d_reg, rx_src, rx_edge;
    logic [CNT_W-1:0] low_cnt_reg, low_cnt_next, rx_thr;
    logic break_hit, brk_reg, brk_next;
    logic idle_o_reg, idle_o_next, ferr_o_reg, ferr_o_next;
    logic full_o_reg, full_o_next, irq_reg, irq_next;
    ulsce_pkg::ulsce_tb_state_t tb_state_reg, tb_state_next;
    logic [CNT_W-1:0] tb_cnt_reg, tb_cnt_next, tx_len;
    logic tb_done_reg, tb_done_next;
    logic tx_level, sw_mode, pin_o_reg, pin_o_next, pin_oe_reg, pin_oe_next;
    logic rx_inv, lin_det;

    assign rx_inv = stat_cfg_reg[`ULSCE_ST_RX_INV];
    assign lin_det = stat_cfg_reg[`ULSCE_ST_LIN_DET];
    assign sw_mode = LOOPBACK_SELECT & RECEIVER_SOURCE_SELECT;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------

    // Read view of the status register
    // Bit five zero
    assign stat_rd = {lbk_flag_reg, edge_flag_reg, 1'b0,
                      stat_cfg_reg, busy_reg};

    // Next state of both bus channels
    always_comb
    begin
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        do_wr = aw_full_reg & w_full_reg & ~bvalid_reg;
        if (S_AXI_AWVALID & awready_reg)
        begin
            aw_full_next = 1'b1;
            awaddr_next = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID & wready_reg)
        begin
            w_full_next = 1'b1;
            wdata_next = S_AXI_WDATA[7:0];
            wstrb_next = S_AXI_WSTRB[0];
        end
        if (bvalid_reg & S_AXI_BREADY)
            bvalid_next = 1'b0;
        if (do_wr)
        begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            if ((awaddr_reg[11:2] == `ULSCE_STATUS_OFS >> 2) ||
                (awaddr_reg[11:2] == `ULSCE_CONTROL_OFS >> 2))
                bresp_next = `ULSCE_RESP_OKAY;
            else
                bresp_next = `ULSCE_RESP_SLVERR;
        end
        if (rvalid_reg & S_AXI_RREADY)
            rvalid_next = 1'b0;
        if (S_AXI_ARVALID & arready_reg)
        begin
            rvalid_next = 1'b1;
            rresp_next = `ULSCE_RESP_OKAY;
            rdata_next = 32'h0000_0000;
            if (S_AXI_ARADDR[11:2] == `ULSCE_STATUS_OFS >> 2)
                rdata_next[7:0] = stat_rd;
            else if (S_AXI_ARADDR[11:2] == `ULSCE_CONTROL_OFS >> 2)
                rdata_next[7:0] = ctrl_reg;
            else
                rresp_next = `ULSCE_RESP_SLVERR;
        end
        awready_next = ~aw_full_next & ~bvalid_next;
        wready_next = ~w_full_next & ~bvalid_next;
        arready_next = ~rvalid_next;
    end

    assign wr_stat = do_wr & wstrb_reg &
                     (awaddr_reg[11:2] == `ULSCE_STATUS_OFS >> 2);
    assign wr_ctrl = do_wr & wstrb_reg &
                     (awaddr_reg[11:2] == `ULSCE_CONTROL_OFS >> 2);

    // Bus channel registers
    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 8'h00;
            wstrb_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `ULSCE_RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= `ULSCE_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Receive path, flags and gating
    // ------------------------------------------------------------

    // Receive source select
    // Single-wire input path
    assign rx_src = sw_mode ? TX_PIN_I :
                    (LOOPBACK_SELECT ? tx_level : RX_PIN);
    assign rx_edge = line_d_reg & ~line_reg;
    assign rx_thr = CNT_W'(`ULSCE_RXBRK_BASE) + CNT_W'(lin_det) +
                    CNT_W'(DATA_NINE_BITS);
    assign break_hit = RX_BIT_TICK & ~line_reg &
                       (low_cnt_reg == rx_thr - CNT_W'(1));

    // Next values of status, control and receive state
    always_comb
    begin
        line_next = rx_src ^ rx_inv;
        stat_cfg_next = stat_cfg_reg;
        ctrl_next = ctrl_reg;
        if (wr_stat)
            stat_cfg_next = wdata_reg[4:1];
        if (wr_ctrl)
            ctrl_next[6:0] = wdata_reg[6:0];
        ctrl_next[`ULSCE_CT_RX_NINTH] = rx9_reg;
        low_cnt_next = low_cnt_reg;
        if (RX_BIT_TICK)
        begin
            if (line_reg)
                low_cnt_next = '0;
            else if (low_cnt_reg != rx_thr)
                low_cnt_next = low_cnt_reg + CNT_W'(1);
        end
        brk_next = break_hit;
        lbk_flag_next = (break_hit & lin_det) |
            (lbk_flag_reg & ~(wr_stat & wdata_reg[`ULSCE_ST_LBK]));
        edge_flag_next = rx_edge |
            (edge_flag_reg & ~(wr_stat & wdata_reg[`ULSCE_ST_EDGE]));
        busy_next = CORE_START_VALID | (busy_reg & ~CORE_LINE_IDLE);
        idle_o_next = CORE_IDLE_SET &
            (~RECEIVER_STANDBY | stat_cfg_reg[`ULSCE_ST_WID]);
        ferr_o_next = CORE_FRAME_ERR_SET & CORE_RXFULL_SET & ~lin_det;
        full_o_next = CORE_RXFULL_SET & ~lin_det;
        rx9_next = full_o_next ? RX_NINTH_IN : rx9_reg;
        tx9_out_next = DATA_WRITE ? ctrl_reg[`ULSCE_CT_TX_NINTH] :
                       tx9_out_reg;
        irq_next = (OVERRUN_FLAG & ctrl_reg[`ULSCE_CT_OVR_EN]) |
                   (NOISE_FLAG & ctrl_reg[`ULSCE_CT_NOISE_EN]) |
                   (FRAME_ERROR_FLAG & ctrl_reg[`ULSCE_CT_FRAME_EN]) |
                   (PARITY_FLAG & ctrl_reg[`ULSCE_CT_PARITY_EN]);
    end

    // Status, control and receive registers
    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            line_reg <= 1'b1;
            line_d_reg <= 1'b1;
            stat_cfg_reg <= 4'h0;
            ctrl_reg <= `ULSCE_CONTROL_RST;
            low_cnt_reg <= '0;
            brk_reg <= 1'b0;
            lbk_flag_reg <= 1'b0;
            edge_flag_reg <= 1'b0;
            busy_reg <= 1'b0;
            idle_o_reg <= 1'b0;
            ferr_o_reg <= 1'b0;
            full_o_reg <= 1'b0;
            rx9_reg <= 1'b0;
            tx9_out_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            line_reg <= line_next;
            line_d_reg <= line_reg;
            stat_cfg_reg <= stat_cfg_next;
            ctrl_reg <= ctrl_next;
            low_cnt_reg <= low_cnt_next;
            brk_reg <= brk_next;
            lbk_flag_reg <= lbk_flag_next;
            edge_flag_reg <= edge_flag_next;
            busy_reg <= busy_next;
            idle_o_reg <= idle_o_next;
            ferr_o_reg <= ferr_o_next;
            full_o_reg <= full_o_next;
            rx9_reg <= rx9_next;
            tx9_out_reg <= tx9_out_next;
            irq_reg <= irq_next;
        end
    end

    // ------------------------------------------------------------
    // Transmit break and pin drive
    // ------------------------------------------------------------

    assign tx_len = (stat_cfg_reg[`ULSCE_ST_LONG_BRK] ?
                     CNT_W'(`ULSCE_TXBRK_LONG) :
                     CNT_W'(`ULSCE_TXBRK_SHORT)) + CNT_W'(DATA_NINE_BITS);
    assign tx_level = (tb_state_reg == ulsce_pkg::ULSCE_TB_SEND) ?
                      1'b0 : TX_SERIAL_RAW;

    // Break sequencer and pin next values
    always_comb
    begin
        tb_state_next = tb_state_reg;
        tb_cnt_next = tb_cnt_reg;
        tb_done_next = 1'b0;
        case (tb_state_reg)
            ulsce_pkg::ULSCE_TB_IDLE:
            begin
                if (TX_BREAK_REQ)
                begin
                    tb_state_next = ulsce_pkg::ULSCE_TB_SEND;
                    tb_cnt_next = '0;
                end
            end
            ulsce_pkg::ULSCE_TB_SEND:
            begin
                if (TX_BIT_TICK)
                begin
                    tb_cnt_next = tb_cnt_reg + CNT_W'(1);
                    if (tb_cnt_reg == tx_len - CNT_W'(1))
                    begin
                        tb_state_next = ulsce_pkg::ULSCE_TB_IDLE;
                        tb_done_next = 1'b1;
                    end
                end
            end
            default:
                tb_state_next = ulsce_pkg::ULSCE_TB_IDLE;
        endcase
        pin_o_next = tx_level ^ ctrl_reg[`ULSCE_CT_TX_INV];
        pin_oe_next = sw_mode ? ctrl_reg[`ULSCE_CT_DIR] : 1'b1;
    end

    // Break sequencer and pin registers
    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            tb_state_reg <= ulsce_pkg::ULSCE_TB_IDLE;
            tb_cnt_reg <= '0;
            tb_done_reg <= 1'b0;
            pin_o_reg <= 1'b1;
            pin_oe_reg <= 1'b1;
        end
        else
        begin
            tb_state_reg <= tb_state_next;
            tb_cnt_reg <= tb_cnt_next;
            tb_done_reg <= tb_done_next;
            pin_o_reg <= pin_o_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    // Output drive
    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RRESP = rresp_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign TX_PIN_O = pin_o_reg;
    assign TX_PIN_OE = pin_oe_reg;
    assign RX_LINE = line_reg;
    assign TX_BREAK_ACTIVE = (tb_state_reg == ulsce_pkg::ULSCE_TB_SEND);
    assign TX_BREAK_DONE = tb_done_reg;
    assign IDLE_SET_OUT = idle_o_reg;
    assign FRAME_ERR_SET_OUT = ferr_o_reg;
    assign RXFULL_SET_OUT = full_o_reg;
    assign TX_NINTH_OUT = tx9_out_reg;
    assign ERR_IRQ = irq_reg;
    assign RECEIVE_BUSY_FLAG = busy_reg;
    assign BREAK_DETECT = brk_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    sequence s_low_edge;
        line_d_reg && !line_reg;
    endsequence
    sequence s_break_end;
        TX_BIT_TICK && TX_BREAK_ACTIVE && tb_cnt_reg == tx_len - CNT_W'(1);
    endsequence

    property p_edge;
        s_low_edge |=> edge_flag_reg;
    endproperty
    a_edge: assert property (p_edge) else $error("edge flag missed");
    property p_lbk;
        break_hit && lin_det |=> lbk_flag_reg && BREAK_DETECT;
    endproperty
    a_lbk: assert property (p_lbk) else $error("break flag missed");
    property p_thr;
        BREAK_DETECT |-> $past(low_cnt_reg) ==
            CNT_W'(`ULSCE_RXBRK_BASE - 1) + CNT_W'($past(lin_det)) +
            CNT_W'($past(DATA_NINE_BITS));
    endproperty
    a_thr: assert property (p_thr) else $error("break threshold wrong");
    property p_gate;
        (FRAME_ERR_SET_OUT || RXFULL_SET_OUT) |-> !$past(lin_det);
    endproperty
    a_gate: assert property (p_gate) else $error("flag not gated");
    property p_idle;
        IDLE_SET_OUT |-> $past(!RECEIVER_STANDBY ||
                               stat_cfg_reg[`ULSCE_ST_WID]);
    endproperty
    a_idle: assert property (p_idle) else $error("idle not gated");
    property p_brk_end;
        s_break_end |=> TX_BREAK_DONE && !TX_BREAK_ACTIVE;
    endproperty
    a_brk_end: assert property (p_brk_end) else $error("break length");
    property p_dir;
        sw_mode && !ctrl_reg[`ULSCE_CT_DIR] [*2] |-> !TX_PIN_OE;
    endproperty
    a_dir: assert property (p_dir) else $error("pin not input");
    property p_tx_invert;
        TX_BREAK_ACTIVE [*2] |-> TX_PIN_O == $past(ctrl_reg[`ULSCE_CT_TX_INV]);
    endproperty
    a_tx_invert: assert property (p_tx_invert) else $error("break level");
    property p_busy;
        CORE_START_VALID |=> RECEIVE_BUSY_FLAG;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not set");
    property p_irq;
        OVERRUN_FLAG && ctrl_reg[`ULSCE_CT_OVR_EN] |=> ERR_IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("overrun request");

endmodule : ulsce_top

// >>> ulsce_node.sv
// Remote serial node model: drives the receive pin, shares the single wire
`timescale 1ns/1ps

module ulsce_node (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic RX_BIT_TICK,
    input wire logic NODE_GO,
    input wire logic NODE_INV,
    input wire logic [3:0] NODE_BITS,
    input wire logic TX_PIN_O,
    input wire logic TX_PIN_OE,
    output logic RX_PIN,
    output logic TX_PIN_I,
    output logic NODE_BUSY
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    // Dominant bits counted out on receive bit ticks
    always_comb
    begin
        cnt_next = cnt_reg;
        if (RX_BIT_TICK && cnt_reg != 4'h0)
            cnt_next = cnt_reg - 4'h1;
        else if (RX_BIT_TICK && NODE_GO)
            cnt_next = NODE_BITS;
    end

    // Bit counter register
    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
            cnt_reg <= 4'h0;
        else
            cnt_reg <= cnt_next;
    end

    // Idle level high, flipped when the node line is inverted
    assign RX_PIN = NODE_INV ^ (cnt_reg == 4'h0);
    assign NODE_BUSY = (cnt_reg != 4'h0);
    // Released wire is pulled up
    assign TX_PIN_I = TX_PIN_OE ? TX_PIN_O : 1'b1;
endmodule : ulsce_node

// >>> tb.sv
// Self-checking bench for the line status and control block
`timescale 1ns/1ps
`include "ulsce_regs.svh"

module tb;
    localparam logic [11:0] ST = `ULSCE_STATUS_OFS;
    localparam logic [11:0] CT = `ULSCE_CONTROL_OFS;
    logic REF_CLK = 1'b0;
    logic RESETN = 1'b0;
    logic [11:0] S_AXI_AWADDR = 12'h000;
    logic [11:0] S_AXI_ARADDR = 12'h000;
    logic [31:0] S_AXI_WDATA = 32'h0;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID, RX_PIN, TX_PIN_I, TX_PIN_O, TX_PIN_OE, RX_LINE;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
    logic [31:0] S_AXI_RDATA, d;
    logic DATA_NINE_BITS = 1'b0, RECEIVER_STANDBY = 1'b0;
    logic LOOPBACK_SELECT = 1'b0, RECEIVER_SOURCE_SELECT = 1'b0;
    logic RX_BIT_TICK = 1'b0, TX_BIT_TICK = 1'b0, TX_SERIAL_RAW = 1'b1;
    logic RX_NINTH_IN = 1'b0, NODE_GO = 1'b0, NODE_INV = 1'b0, NODE_BUSY;
    logic TX_BREAK_ACTIVE, TX_BREAK_DONE, IDLE_SET_OUT, FRAME_ERR_SET_OUT, b;
    logic RXFULL_SET_OUT, TX_NINTH_OUT, ERR_IRQ, RECEIVE_BUSY_FLAG;
    logic BREAK_DETECT;
    logic [3:0] NODE_BITS = 4'h0;
    logic [3:0] flags = 4'h0;
    logic [7:0] pv = 8'h00;
    logic [7:0] e, cfg;
    logic [6:0] rxt [4] = '{7'h0A, 7'h5B, 7'h3B, 7'h6C};
    logic [5:0] txt [4] = '{6'h0A, 6'h1B, 6'h2D, 6'h3E};
    int mismatches = 0;
    int samples_checked = 0;
    int pc [5] = '{0, 0, 0, 0, 0};
    int tc = 0;
    int n, i;
    // Core pulses and error flag levels
    wire TX_BREAK_REQ = pv[0], CORE_START_VALID = pv[1];
    wire CORE_LINE_IDLE = pv[2], CORE_IDLE_SET = pv[3];
    wire CORE_FRAME_ERR_SET = pv[4], CORE_RXFULL_SET = pv[4] | pv[5];
    wire DATA_WRITE = pv[6];
    wire OVERRUN_FLAG = flags[3], NOISE_FLAG = flags[2];
    wire FRAME_ERROR_FLAG = flags[1], PARITY_FLAG = flags[0];

    ulsce_top #(.CNT_W(4)) dut (.*);
    ulsce_node node (.*);

    // Bus clock and bit-rate ticks
    always #20 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK)
    begin
        tc <= tc + 1;
        RX_BIT_TICK <= (tc % 8 == 7);
        TX_BIT_TICK <= (tc % 5 == 4);
    end

    // Pulse counters sampled mid-cycle
    always @(negedge REF_CLK)
    begin
        pc[0] += int'(BREAK_DETECT);
        pc[1] += int'(FRAME_ERR_SET_OUT);
        pc[2] += int'(IDLE_SET_OUT);
        pc[3] += int'(RXFULL_SET_OUT);
        pc[4] += int'(TX_BREAK_ACTIVE & TX_BIT_TICK);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Write: address and data offered together, each dropped once taken
    task automatic axw(input logic [11:0] a, input logic [7:0] v,
                       output logic [1:0] rs);
        logic ta, tw, bv;
        @(posedge REF_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {24'h00_0000, v};
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
        do
        begin
            @(negedge REF_CLK);
            ta = S_AXI_AWVALID & S_AXI_AWREADY;
            tw = S_AXI_WVALID & S_AXI_WREADY;
            bv = S_AXI_BVALID;
            rs = S_AXI_BRESP;
            @(posedge REF_CLK);
            if (ta)
                S_AXI_AWVALID <= 1'b0;
            if (tw)
                S_AXI_WVALID <= 1'b0;
        end while (!bv);
        S_AXI_BREADY <= 1'b0;
    endtask : axw

    task automatic axr(input logic [11:0] a, output logic [31:0] v,
                       output logic [1:0] rs);
        logic ta, rv;
        @(posedge REF_CLK);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
        do
        begin
            @(negedge REF_CLK);
            ta = S_AXI_ARVALID & S_AXI_ARREADY;
            rv = S_AXI_RVALID;
            v = S_AXI_RDATA;
            rs = S_AXI_RRESP;
            @(posedge REF_CLK);
            if (ta)
                S_AXI_ARVALID <= 1'b0;
        end while (!rv);
        S_AXI_RREADY <= 1'b0;
    endtask : axr

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        axr(a, d, r);
        chk(d, x);
    endtask : rd

    task automatic wt(input int k);
        repeat (k) @(posedge REF_CLK);
        @(negedge REF_CLK);
    endtask : wt

    task automatic pulse(input int k);
        @(posedge REF_CLK);
        pv[k] <= 1'b1;
        @(posedge REF_CLK);
        pv <= 8'h00;
        repeat (3) @(posedge REF_CLK);
    endtask : pulse

    // Node drives k dominant bit times, then the line idles
    task automatic send(input logic [3:0] k);
        @(posedge REF_CLK);
        NODE_BITS <= k;
        NODE_GO <= 1'b1;
        do
        begin
            @(negedge REF_CLK);
            b = NODE_BUSY;
            @(posedge REF_CLK);
        end while (!b);
        NODE_GO <= 1'b0;
        do @(negedge REF_CLK); while (NODE_BUSY);
        repeat (20) @(posedge REF_CLK);
    endtask : send

    task automatic end_sim;
        $display("Compared %0d, mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge REF_CLK);
        mismatches++;
        end_sim();
    end

    // Test sequence
    initial
    begin
        repeat (4) @(posedge REF_CLK);
        RESETN <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        rd(ST, 32'h0);
        rd(CT, 32'h0);
        axw(12'h010, 8'hFF, r);
        chk(r, `ULSCE_RESP_SLVERR);
        rd(12'h010, 32'h0);
        chk(r, `ULSCE_RESP_SLVERR);
        axw(ST, 8'hFF, r);
        rd(ST, 32'h5E);
        axw(ST, 8'hC0, r);
        rd(ST, 32'h00);
        $display("registers done");
        pulse(1);
        rd(ST, 32'h01);
        chk(RECEIVE_BUSY_FLAG, 1'b1);
        pulse(2);
        rd(ST, 32'h0);
        RECEIVER_STANDBY <= 1'b1;
        pulse(3);
        chk(pc[2], 32'h0);
        axw(ST, 8'h08, r);
        pulse(3);
        chk(pc[2], 32'h1);
        axw(ST, 8'h04, r);
        RECEIVER_STANDBY <= 1'b0;
        RX_NINTH_IN <= 1'b1;
        pulse(4);
        chk(pc[1], 32'h1);
        chk(pc[3], 32'h1);
        axw(ST, 8'h02, r);
        pulse(4);
        chk(pc[1] + pc[3], 32'h2);
        axw(ST, 8'h00, r);
        axw(CT, 8'h40, r);
        pulse(6);
        rd(CT, 32'hC0);
        wt(1);
        chk(TX_NINTH_OUT, 1'b1);
        $display("receive gates done");
        for (i = 0; i < 4; i++)
        begin
            @(posedge REF_CLK);
            flags <= 4'h1 << i;
            axw(CT, 8'h0F & ~(8'h01 << i), r);
            wt(2);
            chk(ERR_IRQ, 1'b0);
            axw(CT, 8'h01 << i, r);
            wt(2);
            chk(ERR_IRQ, 1'b1);
        end
        $display("error requests done");
        for (i = 0; i < 8; i++)
        begin
            @(posedge REF_CLK);
            {LOOPBACK_SELECT, RECEIVER_SOURCE_SELECT} <= 2'b11;
            TX_SERIAL_RAW <= i[2];
            axw(CT, {2'b00, i[1], i[0], 4'h0}, r);
            wt(2);
            chk({TX_PIN_OE, TX_PIN_O}, {i[1], i[2] ^ i[0]});
            chk(RX_LINE, {i[1] ? i[2] ^ i[0] : 1'b1});
        end
        @(posedge REF_CLK);
        {LOOPBACK_SELECT, RECEIVER_SOURCE_SELECT} <= 2'b00;
        $display("pin direction done");
        for (i = 0; i < 4; i++)
        begin
            e = {1'b0, rxt[i]};
            @(posedge REF_CLK);
            DATA_NINE_BITS <= e[6];
            NODE_INV <= e[4];
            cfg = {2'b11, 1'b0, e[4], 2'b00, e[5], 1'b0};
            axw(ST, cfg, r);
            wt(20);
            axw(ST, cfg, r);
            n = pc[0];
            send(e[3:0] - 4'h1);
            chk(pc[0], n);
            send(e[3:0]);
            chk(pc[0], n + 1);
            rd(ST, {e[5], 2'b10, e[4], 2'b00, e[5], 1'b0});
            axw(ST, cfg, r);
            rd(ST, {3'b000, e[4], 2'b00, e[5], 1'b0});
        end
        $display("break detect done");
        for (i = 0; i < 4; i++)
        begin
            e = {2'b00, txt[i]};
            @(posedge REF_CLK);
            DATA_NINE_BITS <= e[4];
            axw(ST, {5'b00000, e[5], 2'b00}, r);
            n = pc[4];
            pulse(0);
            do @(negedge REF_CLK); while (!TX_BREAK_DONE);
            @(posedge REF_CLK);
            chk(pc[4] - n, e[3:0]);
        end
        $display("break transmit done");
        end_sim();
    end
endmodule : tb
